//--- rtl/emb_ctrl.sv
// Purpose: External 16-bit multiplexed memory bus controller with control register
// Assumes: Core issues one access request at a time and waits for done
// Notes: Pins are split into input, output and output enable
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module emb_ctrl (
   input wire logic SYS_CLK_I,
   input wire logic SYS_RST_I,
   input wire logic [1:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [7:0] REG_RDATA_O,
   input wire logic BUS16_STRAP_I,
   input wire logic SLEEP_I,
   input wire logic REQ_VALID_I,
   input wire logic [1:0] REQ_OP_I,
   input wire logic [15:0] TABLE_POINTER_I,
   input wire logic [7:0] TABLE_LATCH_I,
   output logic REQ_DONE_O,
   output logic [15:0] RD_DATA_O,
   input wire logic [15:0] ADDR_DATA_BUS_I,
   output logic [15:0] ADDR_DATA_BUS_O,
   output logic ADDR_DATA_BUS_OE_O,
   output logic ADDRESS_LATCH_STROBE_O,
   output logic OUTPUT_ENABLE_N_O,
   output logic CHIP_SELECT_N_O,
   output logic WRITE_HIGH_STROBE_N_O,
   output logic WRITE_LOW_STROBE_N_O,
   output logic BYTE_ADDR_LSB_O,
   output logic UPPER_BYTE_ENABLE_N_O,
   output logic LOWER_BYTE_ENABLE_N_O,
   output logic PINS_OE_O
);
   typedef struct packed {
      emb_pkg::emb_state_t state;
      logic [1:0] op;
      logic [7:0] ctrl;
      logic [7:0] hold;
      logic [1:0] wait_cnt;
      logic [15:0] ptr;
      logic [7:0] tlat;
      logic [7:0] rdata;
      logic [15:0] rd_word;
      logic done;
      logic bus16;
      logic strap_done;
      logic [15:0] ad_out;
      logic ad_oe;
      logic ale;
      logic oe_n;
      logic ce_n;
      logic wrh_n;
      logic wrl_n;
      logic ba0;
      logic ub_n;
      logic lb_n;
   } emb_regs_t;

   emb_regs_t r_reg;
   emb_regs_t r_next;
   logic sg_wrh;
   logic sg_wrl;
   logic sg_ub;
   logic sg_lb;
   logic sg_drive;
   logic is_table;
   logic is_write;

   function automatic logic [1:0] emb_waits(input logic [1:0] code);
      emb_waits = emb_pkg::EMB_STALL_MAX - code;
   endfunction : emb_waits

   emb_strobe_gen u_strobe (
      .wmode_i(r_reg.ctrl[emb_pkg::EMB_WMODE_HI:emb_pkg::EMB_WMODE_LO]),
      .lsb_i(r_reg.ptr[0]),
      .wr_hi_o(sg_wrh),
      .wr_lo_o(sg_wrl),
      .ub_o(sg_ub),
      .lb_o(sg_lb),
      .drive_o(sg_drive)
   );

   assign is_table = (r_reg.op != 2'(emb_pkg::EMB_OP_FETCH));
   assign is_write = (r_reg.op == 2'(emb_pkg::EMB_OP_WRITE));

   always_comb begin
      r_next = r_reg;
      r_next.done = 1'b0;
      // Strap is caught once after reset release, never under reset
      if (!r_reg.strap_done) begin
         r_next.bus16 = BUS16_STRAP_I;
         r_next.strap_done = 1'b1;
      end
      if (REG_WR_I && REG_ADDR_I == emb_pkg::EMB_REG_CTRL) begin
         r_next.ctrl = REG_WDATA_I & emb_pkg::EMB_CTRL_MASK;
      end
      case (REG_ADDR_I)
         emb_pkg::EMB_REG_CTRL: r_next.rdata = r_reg.ctrl;
         emb_pkg::EMB_REG_STAT: r_next.rdata = {5'h00, r_reg.bus16, r_reg.ce_n,
            (r_reg.state != emb_pkg::EMB_IDLE)};
         emb_pkg::EMB_REG_HOLD: r_next.rdata = r_reg.hold;
         default: r_next.rdata = 8'h00;
      endcase
      if (!REG_RD_I) begin
         r_next.rdata = 8'h00;
      end
      // Idle pin levels between accesses
      r_next.ad_oe = 1'b0;
      r_next.ale = 1'b0;
      r_next.oe_n = 1'b1;
      r_next.ce_n = 1'b1;
      r_next.wrh_n = 1'b1;
      r_next.wrl_n = 1'b1;
      r_next.ub_n = 1'b1;
      r_next.lb_n = 1'b1;
      r_next.ba0 = 1'b0;
      case (r_reg.state)
         emb_pkg::EMB_IDLE: begin
            if (REQ_VALID_I && !SLEEP_I && r_reg.bus16 && r_reg.strap_done) begin
               r_next.op = REQ_OP_I;
               r_next.ptr = TABLE_POINTER_I;
               r_next.tlat = TABLE_LATCH_I;
               r_next.wait_cnt = emb_waits(r_reg.ctrl[emb_pkg::EMB_STALL_HI:
                  emb_pkg::EMB_STALL_LO]);
               r_next.ad_out = TABLE_POINTER_I;
               r_next.ad_oe = 1'b1;
               r_next.ale = 1'b1;
               r_next.ce_n = 1'b0;
               r_next.state = emb_pkg::EMB_ADDR;
            end else if (REQ_VALID_I && !SLEEP_I) begin
               // No bus fitted: complete at once so the core never hangs
               r_next.done = 1'b1;
               r_next.rd_word = 16'h0000;
            end
         end
         emb_pkg::EMB_ADDR, emb_pkg::EMB_WAIT: begin
            r_next.ce_n = 1'b0;
            r_next.ba0 = r_reg.ptr[0];
            if (is_table && r_reg.wait_cnt != 2'h0) begin
               r_next.wait_cnt = r_reg.wait_cnt - 2'h1;
               r_next.state = emb_pkg::EMB_WAIT;
            end else begin
               r_next.state = emb_pkg::EMB_DATA;
            end
            if (r_next.state == emb_pkg::EMB_DATA) begin
               if (is_write) begin
                  r_next.ad_oe = sg_drive;
                  r_next.wrh_n = ~sg_wrh;
                  r_next.wrl_n = ~sg_wrl;
                  r_next.ub_n = ~sg_ub;
                  r_next.lb_n = ~sg_lb;
                  if (r_reg.ctrl[emb_pkg::EMB_WMODE_HI] && r_reg.ptr[0]) begin
                     r_next.ad_out = {r_reg.tlat, r_reg.hold};
                  end else begin
                     r_next.ad_out = {r_reg.tlat, r_reg.tlat};
                  end
                  if (r_reg.ctrl[emb_pkg::EMB_WMODE_HI] && !r_reg.ptr[0]) begin
                     r_next.hold = r_reg.tlat;
                  end
               end else begin
                  r_next.oe_n = 1'b0;
                  r_next.ub_n = 1'b0;
                  r_next.lb_n = 1'b0;
               end
            end
         end
         emb_pkg::EMB_DATA: begin
            if (!is_write) begin
               r_next.rd_word = ADDR_DATA_BUS_I;
            end
            r_next.done = 1'b1;
            r_next.state = emb_pkg::EMB_DONE;
         end
         emb_pkg::EMB_DONE: begin
            r_next.state = emb_pkg::EMB_IDLE;
         end
         default: r_next.state = emb_pkg::EMB_IDLE;
      endcase
      if (SLEEP_I) begin
         r_next.ce_n = 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         r_reg <= '0;
         r_reg.state <= emb_pkg::EMB_IDLE;
         r_reg.ctrl <= emb_pkg::EMB_CTRL_RST;
         r_reg.oe_n <= 1'b1;
         r_reg.ce_n <= 1'b1;
         r_reg.wrh_n <= 1'b1;
         r_reg.wrl_n <= 1'b1;
         r_reg.ub_n <= 1'b1;
         r_reg.lb_n <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign REG_RDATA_O = r_reg.rdata;
   assign REQ_DONE_O = r_reg.done;
   assign RD_DATA_O = r_reg.rd_word;
   assign ADDR_DATA_BUS_O = r_reg.ad_out;
   assign ADDR_DATA_BUS_OE_O = r_reg.ad_oe;
   assign ADDRESS_LATCH_STROBE_O = r_reg.ale;
   assign OUTPUT_ENABLE_N_O = r_reg.oe_n;
   assign CHIP_SELECT_N_O = r_reg.ce_n;
   assign WRITE_HIGH_STROBE_N_O = r_reg.wrh_n;
   assign WRITE_LOW_STROBE_N_O = r_reg.wrl_n;
   assign BYTE_ADDR_LSB_O = r_reg.ba0;
   assign UPPER_BYTE_ENABLE_N_O = r_reg.ub_n;
   assign LOWER_BYTE_ENABLE_N_O = r_reg.lb_n;
   // An access in flight keeps the pins even if disable was just set
   assign PINS_OE_O = r_reg.bus16 &&
      (!r_reg.ctrl[emb_pkg::EMB_BUS_DIS_BIT] || r_reg.state != emb_pkg::EMB_IDLE);
endmodule : emb_ctrl

//--- rtl/emb_pkg.sv
// Purpose: Constants and types for the 16-bit multiplexed external memory bus controller
// Assumes: One clock (SYS_CLK_I, 10 MHz), synchronous active-high reset
// Notes: Register offsets are plain-port indices; no public bus
package emb_pkg;
   localparam logic [1:0] EMB_REG_CTRL = 2'h0;
   localparam logic [1:0] EMB_REG_STAT = 2'h1;
   localparam logic [1:0] EMB_REG_HOLD = 2'h2;
   localparam int EMB_BUS_DIS_BIT = 7;
   localparam int EMB_STALL_HI = 5;
   localparam int EMB_STALL_LO = 4;
   localparam int EMB_WMODE_HI = 1;
   localparam int EMB_WMODE_LO = 0;
   localparam logic [7:0] EMB_CTRL_RST = 8'h00;
   localparam logic [7:0] EMB_CTRL_MASK = 8'hB3;
   localparam logic [1:0] EMB_WM_BYTE_SEL = 2'h1;
   localparam logic [1:0] EMB_WM_BYTE_WR = 2'h0;
   localparam logic [1:0] EMB_STALL_MAX = 2'h3;
   typedef enum logic [2:0] {
      EMB_IDLE,
      EMB_ADDR,
      EMB_WAIT,
      EMB_DATA,
      EMB_DONE
   } emb_state_t;
   typedef enum logic [1:0] {
      EMB_OP_FETCH,
      EMB_OP_READ,
      EMB_OP_WRITE
   } emb_op_t;
endpackage : emb_pkg

//--- rtl/emb_strobe_gen.sv
// Purpose: Decode write strobes and byte selects from write mode and pointer LSB
// Assumes: Purely combinational; caller gates with the data phase
// Notes: Outputs are active high here; top inverts to pin polarity
`timescale 1ns/1ps
module emb_strobe_gen (
   input wire logic [1:0] wmode_i,
   input wire logic lsb_i,
   output logic wr_hi_o,
   output logic wr_lo_o,
   output logic ub_o,
   output logic lb_o,
   output logic drive_o
);
   always_comb begin
      wr_hi_o = 1'b0;
      wr_lo_o = 1'b0;
      ub_o = 1'b1;
      lb_o = 1'b1;
      drive_o = 1'b1;
      if (wmode_i[1]) begin
         // Even half only parks data in the holding latch
         wr_hi_o = lsb_i;
         drive_o = lsb_i;
      end else if (wmode_i == emb_pkg::EMB_WM_BYTE_SEL) begin
         wr_hi_o = 1'b1;
         ub_o = lsb_i;
         lb_o = ~lsb_i;
      end else begin
         wr_hi_o = lsb_i;
         wr_lo_o = ~lsb_i;
      end
   end
endmodule : emb_strobe_gen

//--- verif/emb_ctrl_checker.sv
// Purpose: Pin-level checks of the external bus controller
// Assumes: Sees top-level ports only, one clock
// Notes: Sleep inside an access may raise chip select early
`timescale 1ns/1ps
module emb_ctrl_checker (
   input wire logic SYS_CLK_I,
   input wire logic SYS_RST_I,
   input wire logic SLEEP_I,
   input wire logic REQ_DONE_O,
   input wire logic ADDR_DATA_BUS_OE_O,
   input wire logic ADDRESS_LATCH_STROBE_O,
   input wire logic OUTPUT_ENABLE_N_O,
   input wire logic CHIP_SELECT_N_O,
   input wire logic WRITE_HIGH_STROBE_N_O,
   input wire logic WRITE_LOW_STROBE_N_O
);
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (SYS_RST_I);
   AST_ALE_PULSE: assert property (ADDRESS_LATCH_STROBE_O |=> !ADDRESS_LATCH_STROBE_O)
      else $error("latch strobe too long");
   AST_ALE_CS: assert property (ADDRESS_LATCH_STROBE_O |-> !CHIP_SELECT_N_O && ADDR_DATA_BUS_OE_O)
      else $error("address phase without select");
   AST_SLEEP_CS: assert property (SLEEP_I |=> CHIP_SELECT_N_O)
      else $error("select low in sleep");
   AST_WR_EXCL: assert property (!(!WRITE_HIGH_STROBE_N_O && !WRITE_LOW_STROBE_N_O))
      else $error("both write strobes");
   AST_OE_READ: assert property (!OUTPUT_ENABLE_N_O |-> WRITE_HIGH_STROBE_N_O && !ADDR_DATA_BUS_OE_O)
      else $error("output enable during drive");
   AST_WR_DRIVE: assert property (!WRITE_HIGH_STROBE_N_O |-> ADDR_DATA_BUS_OE_O && !ADDRESS_LATCH_STROBE_O)
      else $error("strobe with floating bus");
   AST_ALE_DONE: assert property (ADDRESS_LATCH_STROBE_O |-> ##[2:5] REQ_DONE_O)
      else $error("access too long");
   AST_IDLE: assert property (CHIP_SELECT_N_O && !SLEEP_I && !$past(SLEEP_I) |-> OUTPUT_ENABLE_N_O
      && WRITE_HIGH_STROBE_N_O && WRITE_LOW_STROBE_N_O && !ADDR_DATA_BUS_OE_O)
      else $error("idle pins active");
endmodule : emb_ctrl_checker
bind emb_ctrl emb_ctrl_checker u_chk (.SYS_CLK_I, .SYS_RST_I, .SLEEP_I, .REQ_DONE_O,
   .ADDR_DATA_BUS_OE_O, .ADDRESS_LATCH_STROBE_O, .OUTPUT_ENABLE_N_O, .CHIP_SELECT_N_O,
   .WRITE_HIGH_STROBE_N_O, .WRITE_LOW_STROBE_N_O);

//--- verif/emb_mem_model.sv
// Purpose: Word-wide memory on the multiplexed bus
// Assumes: Address latched on the latch strobe
// Notes: Content is address-derived, writes are judged by the bench
`timescale 1ns/1ps
module emb_mem_model (
   input wire logic clk_i,
   input wire logic ale_i,
   input wire logic oe_n_i,
   input wire logic [15:0] ad_i,
   output logic [15:0] rdata_o
);
   logic [15:0] addr_reg;
   logic [15:0] last_reg = 16'h0000;
   always_ff @(posedge clk_i) begin
      if (ale_i) addr_reg <= ad_i;
      last_reg <= rdata_o;
   end
   // Released bus toggles so a late sample cannot pass
   assign rdata_o = !oe_n_i ? (addr_reg ^ 16'h5A3C) : ~last_reg;
endmodule : emb_mem_model

//--- verif/ext_mem_16bit_write_modes_tb_top.sv
// Purpose: Self-checking bench of the external bus controller
// Assumes: Strap at 16-bit bus until a last reset run without a bus
// Notes: Per-access pin activity is folded and checked at done
`timescale 1ns/1ps
module ext_mem_16bit_write_modes_tb_top;
   typedef struct packed {logic rd; logic [2:0] lat; logic [15:0] d; logic [6:0] f;
      logic [6:0] m;} emb_tb_exp_t;
   logic clk = 1'h0, rst = 1'h1, rwr = 1'h0, rrd = 1'h0, slp = 1'h0, vld = 1'h0, rd_p = 1'h0;
   logic strap = 1'h1;
   logic [1:0] ra = 2'h0, op = 2'h0;
   logic [7:0] rwd = 8'h00, lat = 8'h00, rdat;
   logic [15:0] ptr = 16'h0000, rdw, adi, ado, mrd, wd;
   logic done, adoe, ale, oen, csn, whn, wln, ba0, ubn, lbn, poe;
   logic [6:0] fl;
   logic [2:0] cnt;
   emb_tb_exp_t q[$], e;
   logic [7:0] rq[$];
   int n_mismatch = 0, compares = 0, cyc = 0;
   assign adi = adoe ? ado : mrd;
   emb_ctrl dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(ra), .REG_WDATA_I(rwd),
      .REG_WR_I(rwr), .REG_RD_I(rrd), .REG_RDATA_O(rdat), .BUS16_STRAP_I(strap), .SLEEP_I(slp),
      .REQ_VALID_I(vld), .REQ_OP_I(op), .TABLE_POINTER_I(ptr), .TABLE_LATCH_I(lat),
      .REQ_DONE_O(done), .RD_DATA_O(rdw), .ADDR_DATA_BUS_I(adi), .ADDR_DATA_BUS_O(ado),
      .ADDR_DATA_BUS_OE_O(adoe), .ADDRESS_LATCH_STROBE_O(ale), .OUTPUT_ENABLE_N_O(oen),
      .CHIP_SELECT_N_O(csn), .WRITE_HIGH_STROBE_N_O(whn), .WRITE_LOW_STROBE_N_O(wln),
      .BYTE_ADDR_LSB_O(ba0), .UPPER_BYTE_ENABLE_N_O(ubn), .LOWER_BYTE_ENABLE_N_O(lbn),
      .PINS_OE_O(poe));
   emb_mem_model mem (.clk_i(clk), .ale_i(ale), .oe_n_i(oen), .ad_i(ado), .rdata_o(mrd));
   initial forever #50 clk = ~clk;
   task automatic chk(input logic ok, input string s);
      compares++;
      if (ok !== 1'h1) begin
         n_mismatch++;
         $display("[ERR] %0t %s", $time, s);
      end
   endtask : chk
   task automatic conclude();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude
   task automatic reg_io(input logic w, input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      ra <= a;
      rwd <= d;
      if (w) rwr <= 1'h1;
      else rq.push_back(d);
      rrd <= !w;
      @(posedge clk);
      rwr <= 1'h0;
      rrd <= 1'h0;
   endtask : reg_io
   // Expected pins {drive,wrh,wrl,ub,lb,ba0,oe}; mask skips unspecified ones
   function automatic emb_tb_exp_t ex(input logic [1:0] o, md, w, input logic [15:0] p,
         input logic [7:0] l, h);
      emb_tb_exp_t x;
      x.rd = (o != 2'h2);
      x.lat = (o == 2'h0) ? 3'h1 : 3'h4 - {1'h0, w};
      x.m = 7'h7F;
      x.d = x.rd ? p ^ 16'h5A3C : (md[1] ? (p[0] ? {l, h} : 16'h0000) : {l, l});
      if (x.rd) x.f = {5'h03, p[0], 1'h1};
      else if (md[1]) x.f = p[0] ? 7'h6E : 7'h00;
      else if (md[0]) x.f = {3'h6, p[0], !p[0], p[0], 1'h0};
      else x.f = {1'h1, p[0], !p[0], 4'h0};
      if (!x.rd && md[1] && !p[0]) x.m = 7'h73;
      if (!x.rd && md == 2'h0) x.m = 7'h71;
      return x;
   endfunction : ex
   task automatic acc(input logic [1:0] o, input logic [15:0] p, input logic [7:0] l,
         input emb_tb_exp_t x);
      int n;
      n = 0;
      @(posedge clk);
      q.push_back(x);
      vld <= 1'h1;
      op <= o;
      ptr <= p;
      lat <= l;
      do begin
         @(posedge clk);
         n++;
      end while (done !== 1'h1 && n < 20);
      vld <= 1'h0;
   endtask : acc
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         conclude();
      end
   end
   // Timeout kept in its own process so nothing runs after the finish
   always @(posedge clk) begin
      rd_p <= rrd;
      if (rd_p === 1'h1) chk(rdat === rq.pop_front(), "register read");
      fl <= ale ? 7'h00 : fl | {adoe, !whn, !wln, !ubn, !lbn, ba0, !oen};
      cnt <= ale ? 3'h0 : cnt + 3'h1;
      if (ale === 1'h1) wd <= 16'h0000;
      else if (!whn || !wln) wd <= ado;
      if (done === 1'h1) begin
         e = q.pop_front();
         chk(((fl ^ e.f) & e.m) === 7'h00 && cnt === e.lat && (e.rd ? rdw : wd) === e.d,
            "access");
      end
   end
   initial begin
      logic [15:0] p;
      logic [7:0] l, h;
      logic [1:0] w;
      void'($urandom(32'h2677061E));
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      reg_io(1'h0, 2'h0, 8'h00);
      reg_io(1'h0, 2'h1, 8'h06);
      reg_io(1'h1, 2'h0, 8'hFF);
      reg_io(1'h1, 2'h1, 8'h55);
      reg_io(1'h0, 2'h0, 8'hB3);
      reg_io(1'h0, 2'h3, 8'h00);
      chk(poe === 1'h0, "pins not released");
      reg_io(1'h1, 2'h0, 8'h00);
      @(posedge clk);
      chk(poe === 1'h1, "pins not on bus");
      for (int md = 0; md < 8; md++) begin
         w = 2'($urandom);
         reg_io(1'h1, 2'h0, {2'h0, w, 2'h0, 2'(md)});
         p = 16'($urandom) & 16'hFFFE;
         h = 8'($urandom);
         l = 8'($urandom);
         acc(2'h2, p, h, ex(2'h2, 2'(md), w, p, h, 8'h00));
         if (md[1]) reg_io(1'h0, 2'h2, h);
         acc(2'h2, p | 16'h0001, l, ex(2'h2, 2'(md), w, p | 16'h0001, l, h));
         acc(2'h1, ~p, 8'h00, ex(2'h1, 2'(md), w, ~p, 8'h00, 8'h00));
         acc(2'h0, p, 8'h00, ex(2'h0, 2'(md), w, p, 8'h00, 8'h00));
      end
      @(posedge clk);
      slp <= 1'h1;
      vld <= 1'h1;
      // A request raised in sleep must never start an access
      repeat (4) begin
         @(posedge clk);
         chk(csn === 1'h1 && ale === 1'h0, "select in sleep");
      end
      slp <= 1'h0;
      vld <= 1'h0;
      rst <= 1'h1;
      strap <= 1'h0;
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      reg_io(1'h0, 2'h1, 8'h02);
      chk(poe === 1'h0, "pins kept without bus");
      repeat (2) @(posedge clk);
      chk(q.size() == 0 && rq.size() == 0, "results missing");
      conclude();
   end
endmodule : ext_mem_16bit_write_modes_tb_top
